/* pkg/sab_defines.svh */
/*
  register map, field positions and reset values of the serial audio buffer block.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef SAB_DEFINES_SVH
`define SAB_DEFINES_SVH
`define SAB_OFF_CTRL 4'h0
`define SAB_OFF_CTRL2 4'h4
`define SAB_OFF_STAT 4'h8
`define SAB_OFF_DATA 4'hC
`define SAB_RST_WORD 32'h0000_0000
`define SAB_C_FRAMED_OPERATION_ENABLE 31
`define SAB_C_DEEP 16
`define SAB_C_ON 15
`define SAB_C_M32 11
`define SAB_C_M16 10
`define SAB_C_WMASK 32'h8001_8C0F
`define SAB_C_OFFONLY 32'h0001_0C00
`define SAB_C2_SGN 15
`define SAB_C2_FEEN 12
`define SAB_C2_OVEN 11
`define SAB_C2_UREN 10
`define SAB_C2_IGOV 9
`define SAB_C2_IGUR 8
`define SAB_C2_AUD 7
`define SAB_C2_MONO 3
`define SAB_C2_WMASK 32'h0000_9F8B
`define SAB_C2_OFFONLY 32'h0000_008B
`define SAB_S_FRAME_ERROR_FLAG 12
`define SAB_S_OVF 6
`define SAB_S_RCNT 28:24
`define SAB_S_TCNT 20:16
`define SAB_S_BUSY 11
`define SAB_S_UDR 8
`define SAB_S_SHIFTER_EMPTY_FLAG 7
`define SAB_S_RBE 5
`define SAB_S_TBE 3
`define SAB_S_TBF 1
`define SAB_S_RBF 0
`define SAB_C_TXSEL 3:2
`define SAB_C_RXSEL 1:0
`define SAB_C2_FMT 1:0
`define SAB_FIFO_MAX 16
`define SAB_DEP32 5'h04
`define SAB_DEP16 5'h08
`define SAB_DEP8 5'h10
`define SAB_BITS32 6'h20
`define SAB_BITS16 6'h10
`define SAB_BITS8 6'h08
`define SAB_RESP_OKAY 2'h0
`define SAB_RESP_SLVERR 2'h2
`endif

/* pkg/sab_pkg.sv */
/*
  types of the serial audio buffer block: serial engine states and the module state record.
  assumes sab_defines.svh is on the include path.
*/
`include "sab_defines.svh"
package sab_pkg;
  typedef enum logic [2:0] {SAB_IDLE = 3'b001, SAB_RUN = 3'b010, SAB_HALT = 3'b100} sab_run_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] ctrl2;
    logic frm_err;
    logic ovf;
    logic udr;
    logic [`SAB_FIFO_MAX-1:0][31:0] txm;
    logic [`SAB_FIFO_MAX-1:0][31:0] rxm;
    logic [3:0] twp;
    logic [3:0] trp;
    logic [3:0] rwp;
    logic [3:0] rrp;
    logic [4:0] tcnt;
    logic [4:0] rcnt;
    logic [2:0] ssy;
    logic [2:0] sky;
    logic [1:0] sdy;
    logic [31:0] tsh;
    logic [31:0] rsh;
    logic [5:0] bcnt;
    logic loaded;
    logic lr;
    sab_run_t run;
    logic aw_v;
    logic [3:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sab_state_t;
endpackage

/* rtl/sab_spi.sv */
/*
  serial peripheral slave with audio options, single-word or deep fifos, status and events,
  registers over axi4-lite.
  assumes sck, select and data pins are asynchronous to ref_clk_i and sck is well below
  a quarter of the clock rate; the select pin doubles as frame sync in framed operation.
*/
`include "sab_defines.svh"
// Notes on behaviour
// - tx event by free, half, empty, done
// - rx event by full, half, nonempty, empty
// - optional sign extension of read data
// - frame error event only when enabled
// - overflow event only when enabled
// - underrun event only when enabled
// - ignore overflow keeps fifo, else halt
// - ignore underrun sends zeros, else halt
// - mono sends each word on both channels
// - audio enable and four audio formats
// - audio controls writable only while off
// - mono and format apply only with audio
// - five-bit rx and tx element counts
// - frame error set by hardware, software clears
// - busy while transaction in progress
// - underrun flag cleared by switching off
// - shifter empty status bit
// - overflow on lost word, software writes zero
// - rx empty when pointers are equal and not full
// - tx empty set on shifter load
// - tx full per buffer mode
// - rx full per buffer mode
// - deep fifo enable selects fifo depth
// - depth 4, 8, 16 for 32, 16, 8 bits
module sab_spi
  import sab_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic tx_event_o,
  output logic rx_event_o,
  output logic error_event_o,
  output logic audio_mono_o,
  output logic [1:0] audio_format_o
);

  sab_state_t s_r;
  sab_state_t s_nxt;

  function automatic logic [4:0] sab_depth(input logic [31:0] c);
    if (!c[`SAB_C_DEEP]) return 5'h01;
    if (c[`SAB_C_M32]) return `SAB_DEP32;
    if (c[`SAB_C_M16]) return `SAB_DEP16;
    return `SAB_DEP8;
  endfunction

  function automatic logic [5:0] sab_bits(input logic [31:0] c);
    if (c[`SAB_C_M32]) return `SAB_BITS32;
    if (c[`SAB_C_M16]) return `SAB_BITS16;
    return `SAB_BITS8;
  endfunction

  function automatic logic [31:0] sab_mask(input logic [5:0] b);
    if (b == `SAB_BITS32) return 32'hFFFF_FFFF;
    if (b == `SAB_BITS16) return 32'h0000_FFFF;
    return 32'h0000_00FF;
  endfunction

  function automatic logic [31:0] sab_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] st, input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic [3:0] sab_inc(input logic [3:0] p, input logic [4:0] dep);
    logic [3:0] lim;
    lim = 4'(dep - 5'h01);
    return (p + 4'h1) & lim;
  endfunction

  logic on;
  logic aud;
  logic mono;
  logic [4:0] dep;
  logic [5:0] bits;
  logic sel;
  logic tx_full;
  logic rx_full;
  logic [31:0] stat;
  logic [31:0] rd_word;

  assign on = s_r.ctrl[`SAB_C_ON];
  assign aud = s_r.ctrl2[`SAB_C2_AUD];
  assign mono = aud & s_r.ctrl2[`SAB_C2_MONO];
  assign dep = sab_depth(s_r.ctrl);
  assign bits = sab_bits(s_r.ctrl);
  assign sel = ~s_r.ssy[1];
  // full as occupied == depth, which equals the pointer relation once the pointer wraps
  assign tx_full = (s_r.tcnt == dep);
  assign rx_full = (s_r.rcnt == dep);

  always_comb
  begin
    stat = `SAB_RST_WORD;
    stat[`SAB_S_RCNT] = s_r.rcnt;
    stat[`SAB_S_TCNT] = s_r.tcnt;
    stat[`SAB_S_FRAME_ERROR_FLAG] = s_r.frm_err;
    stat[`SAB_S_BUSY] = sel | (s_r.bcnt != 6'h00);
    stat[`SAB_S_UDR] = s_r.udr;
    stat[`SAB_S_SHIFTER_EMPTY_FLAG] = ~s_r.loaded;
    stat[`SAB_S_OVF] = s_r.ovf;
    stat[`SAB_S_RBE] = (s_r.rrp == s_r.rwp) & ~rx_full;
    stat[`SAB_S_TBE] = (s_r.tcnt == 5'h00);
    stat[`SAB_S_TBF] = tx_full;
    stat[`SAB_S_RBF] = rx_full;
  end

  always_comb
  begin
    rd_word = s_r.rxm[s_r.rrp];
    if (s_r.ctrl2[`SAB_C2_SGN])
    begin
      if (bits == `SAB_BITS8)
        rd_word = {{24{rd_word[7]}}, rd_word[7:0]};
      else if (bits == `SAB_BITS16)
        rd_word = {{16{rd_word[15]}}, rd_word[15:0]};
    end
  end

  always_comb
  begin
    logic tpush;
    logic tpop;
    logic rpush;
    logic rpop;
    logic ovf_set;
    logic fe_set;
    logic [5:0] nb;
    tpush = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    ovf_set = 1'b0;
    fe_set = 1'b0;
    nb = 6'h00;
    s_nxt = s_r;

    s_nxt.ssy = {s_r.ssy[1:0], sel_n_i};
    s_nxt.sky = {s_r.sky[1:0], sck_i};
    s_nxt.sdy = {s_r.sdy[0], sdi_i};

    // axi4-lite: address and data taken in either order, one response per write
    if (s_axi_awvalid_i && !s_r.aw_v && !s_r.bvalid)
    begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !s_r.w_v && !s_r.bvalid)
    begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = s_axi_wdata_i;
      s_nxt.w_s = s_axi_wstrb_i;
    end
    if (s_r.bvalid && s_axi_bready_i)
      s_nxt.bvalid = 1'b0;
    if (s_r.aw_v && s_r.w_v)
    begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `SAB_RESP_OKAY;
      unique case (s_r.aw_a)
        `SAB_OFF_CTRL:
          // depth and width change only while off, so fifo contents stay coherent
          s_nxt.ctrl = sab_merge(s_r.ctrl, s_r.w_d, s_r.w_s,
                                 on ? (`SAB_C_WMASK & ~`SAB_C_OFFONLY) : `SAB_C_WMASK);
        `SAB_OFF_CTRL2:
          s_nxt.ctrl2 = sab_merge(s_r.ctrl2, s_r.w_d, s_r.w_s,
                                  on ? (`SAB_C2_WMASK & ~`SAB_C2_OFFONLY)
                                     : `SAB_C2_WMASK);
        `SAB_OFF_STAT:
        begin
          if (s_r.w_s[0] && !s_r.w_d[`SAB_S_OVF])
            s_nxt.ovf = 1'b0;
          if (s_r.w_s[1] && !s_r.w_d[`SAB_S_FRAME_ERROR_FLAG])
            s_nxt.frm_err = 1'b0;
        end
        `SAB_OFF_DATA:
          tpush = on & ~tx_full;
        default:
          s_nxt.bresp = `SAB_RESP_SLVERR;
      endcase
    end

    if (s_r.rvalid && s_axi_rready_i)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid_i && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `SAB_RESP_OKAY;
      unique case (s_axi_araddr_i)
        `SAB_OFF_CTRL: s_nxt.rdata = s_r.ctrl;
        `SAB_OFF_CTRL2: s_nxt.rdata = s_r.ctrl2;
        `SAB_OFF_STAT: s_nxt.rdata = stat;
        `SAB_OFF_DATA:
        begin
          s_nxt.rdata = (s_r.rcnt != 5'h00) ? rd_word : `SAB_RST_WORD;
          rpop = (s_r.rcnt != 5'h00);
        end
        default:
        begin
          s_nxt.rdata = `SAB_RST_WORD;
          s_nxt.rresp = `SAB_RESP_SLVERR;
        end
      endcase
    end

    // serial engine
    unique case (s_r.run)
      SAB_IDLE:
        if (on)
          s_nxt.run = SAB_RUN;
      SAB_RUN:
      begin
        if (!s_r.ssy[2] && s_r.ssy[1] && s_r.bcnt != 6'h00)
        begin
          fe_set = s_r.ctrl[`SAB_C_FRAMED_OPERATION_ENABLE];
          s_nxt.bcnt = 6'h00;
        end
        else if (sel && !s_r.loaded && s_r.bcnt == 6'h00)
        begin
          s_nxt.loaded = 1'b1;
          if (s_r.tcnt != 5'h00)
          begin
            s_nxt.tsh = (s_r.txm[s_r.trp] & sab_mask(bits)) << (`SAB_BITS32 - bits);
            tpop = ~mono | s_r.lr;
            s_nxt.lr = mono & ~s_r.lr;
          end
          else
          begin
            s_nxt.udr = 1'b1;
            s_nxt.tsh = `SAB_RST_WORD;
            if (!s_r.ctrl2[`SAB_C2_IGUR])
              s_nxt.run = SAB_HALT;
          end
        end
        else if (sel && s_r.sky[1] && !s_r.sky[2])
        begin
          nb = s_r.bcnt + 6'h01;
          s_nxt.rsh = {s_r.rsh[30:0], s_r.sdy[1]};
          s_nxt.bcnt = nb;
          if (nb == bits)
          begin
            s_nxt.bcnt = 6'h00;
            s_nxt.loaded = 1'b0;
            if (rx_full && !rpop)
            begin
              ovf_set = 1'b1;
              if (!s_r.ctrl2[`SAB_C2_IGOV])
                s_nxt.run = SAB_HALT;
            end
            else
              rpush = 1'b1;
          end
        end
        else if (sel && !s_r.sky[1] && s_r.sky[2] && s_r.bcnt != 6'h00)
          s_nxt.tsh = {s_r.tsh[30:0], 1'b0};
      end
      SAB_HALT: ;
      default:
        s_nxt.run = SAB_IDLE;
    endcase

    if (tpush)
    begin
      s_nxt.txm[s_r.twp] = s_r.w_d;
      s_nxt.twp = sab_inc(s_r.twp, dep);
    end
    if (tpop)
      s_nxt.trp = sab_inc(s_r.trp, dep);
    s_nxt.tcnt = s_r.tcnt + {4'h0, tpush} - {4'h0, tpop};
    if (rpush)
    begin
      // the fifo is left untouched on overflow: the new word is the one discarded
      s_nxt.rxm[s_r.rwp] = s_nxt.rsh & sab_mask(bits);
      s_nxt.rwp = sab_inc(s_r.rwp, dep);
    end
    if (rpop)
      s_nxt.rrp = sab_inc(s_r.rrp, dep);
    s_nxt.rcnt = s_r.rcnt + {4'h0, rpush} - {4'h0, rpop};
    // hardware set wins over a software clear in the same cycle
    if (ovf_set)
      s_nxt.ovf = 1'b1;
    if (fe_set)
      s_nxt.frm_err = 1'b1;

    if (!on)
    begin
      s_nxt.run = SAB_IDLE;
      s_nxt.udr = 1'b0;
      s_nxt.twp = 4'h0;
      s_nxt.trp = 4'h0;
      s_nxt.rwp = 4'h0;
      s_nxt.rrp = 4'h0;
      s_nxt.tcnt = 5'h00;
      s_nxt.rcnt = 5'h00;
      s_nxt.bcnt = 6'h00;
      s_nxt.loaded = 1'b0;
      s_nxt.lr = 1'b0;
      s_nxt.tsh = `SAB_RST_WORD;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_r <= '0;
      s_r.run <= SAB_IDLE;
      s_r.ssy <= 3'h7;
    end
    else
      s_r <= s_nxt;
  end

  assign s_axi_awready_o = ~s_r.aw_v & ~s_r.bvalid;
  assign s_axi_wready_o = ~s_r.w_v & ~s_r.bvalid;
  assign s_axi_bvalid_o = s_r.bvalid;
  assign s_axi_bresp_o = s_r.bresp;
  assign s_axi_arready_o = ~s_r.rvalid;
  assign s_axi_rvalid_o = s_r.rvalid;
  assign s_axi_rdata_o = s_r.rdata;
  assign s_axi_rresp_o = s_r.rresp;
  assign sdo_o = s_r.tsh[31];
  assign audio_mono_o = mono;
  assign audio_format_o = aud ? s_r.ctrl2[`SAB_C2_FMT] : 2'h0;

  always_comb
  begin
    unique case (s_r.ctrl[`SAB_C_TXSEL])
      2'h3: tx_event_o = on & ~tx_full;
      2'h2: tx_event_o = on & ({s_r.tcnt, 1'b0} <= {1'b0, dep});
      2'h1: tx_event_o = on & (s_r.tcnt == 5'h00);
      2'h0: tx_event_o = on & (s_r.tcnt == 5'h00) & ~s_r.loaded & (s_r.bcnt == 6'h00);
    endcase
    unique case (s_r.ctrl[`SAB_C_RXSEL])
      2'h3: rx_event_o = on & rx_full;
      2'h2: rx_event_o = on & ({s_r.rcnt, 1'b0} >= {1'b0, dep});
      2'h1: rx_event_o = on & (s_r.rcnt != 5'h00);
      2'h0: rx_event_o = on & (s_r.rcnt == 5'h00);
    endcase
  end

  assign error_event_o = (s_r.frm_err & s_r.ctrl2[`SAB_C2_FEEN])
                       | (s_r.ovf & s_r.ctrl2[`SAB_C2_OVEN])
                       | (s_r.udr & s_r.ctrl2[`SAB_C2_UREN]);

endmodule // sab_spi

/* sim/sab_spi_sva.sv */
/*
  bus handshake and output checks of the serial audio buffer block.
  assumes it sees only top-level ports; bound to every sab_spi instance.
*/
module sab_spi_sva (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic tx_event_o,
  input wire logic rx_event_o,
  input wire logic error_event_o,
  input wire logic audio_mono_o,
  input wire logic [1:0] audio_format_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wr_block;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("ready while response pending");
  property p_rd_block;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("arready while rvalid");
  property p_b_stand;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_r_stand;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  property p_rd_lat;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing");
  property p_aw_held;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  a_aw_held: assert property (p_aw_held) else $error("address not held");
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  a_b_done: assert property (p_b_done) else $error("response not retired");
  property p_rst_quiet;
    $fell(sys_rst_i) |-> !tx_event_o && !rx_event_o && !error_event_o && !audio_mono_o
      && audio_format_o == 2'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  // audio outputs move only with a performed register write
  property p_aud_write;
    $changed(audio_format_o) || $changed(audio_mono_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  a_aud_write: assert property (p_aud_write) else $error("audio output moved");
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  c_err: cover property ($rose(error_event_o));
  c_mono: cover property (audio_mono_o);
endmodule // sab_spi_sva

bind sab_spi sab_spi_sva u_sva (.ref_clk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .tx_event_o, .rx_event_o, .error_event_o, .audio_mono_o, .audio_format_o);

/* sim/sab_link_model.sv */
/*
  serial master model: clock idle low, msb first, one frame per call.
  assumes the slave presents its first bit soon after select falls.
*/
module sab_link_model (
  output logic sck_o,
  output logic sel_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    sel_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = tx[i];
      #62.5 sck_o = 1'b1;
      rx = {rx[30:0], sdo_i};
      #62.5 sck_o = 1'b0;
    end
    sel_n_o = 1'b1;
    // released data line must not look like a held bit
    sdi_o = !sdi_o;
    #100;
  endtask
endmodule // sab_link_model

/* sim/sab_spi_test.sv */
/*
  self-checking bench of the serial audio buffer block: registers, audio, link, flags.
  assumes sab_spi, its checker and sab_link_model are compiled before it.
*/
module sab_spi_test;
  import sab_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [3:0] a; logic [31:0] wd, m, ex; logic [1:0] rs;} sab_row_t;
  logic ref_clk_i, sys_rst_i = 1'b1;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, audio_format_o;
  logic [31:0] s_axi_rdata_o, d, g1, g2, g3;
  logic sck_i, sel_n_i, sdi_i, sdo_o, tx_event_o, rx_event_o, error_event_o, audio_mono_o;
  logic [1:0] r;
  int n_mismatch = 0, tests_run = 0;
  sab_row_t rows [8] = '{
    '{1'b0, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 2'h0},
    '{1'b0, 4'h4, 32'h0, 32'hFFFF_FFFF, 32'h0, 2'h0},
    '{1'b0, 4'h8, 32'h0, 32'h1F1F_19EB, 32'h0000_00A8, 2'h0},
    '{1'b1, 4'h4, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_9F8B, 2'h0},
    '{1'b1, 4'h4, 32'h0, 32'hFFFF_FFFF, 32'h0, 2'h0},
    '{1'b1, 4'h0, 32'h0000_000F, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0},
    '{1'b1, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 2'h0},
    '{1'b1, 4'h6, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 2'h2}};
  sab_spi u_dut (.ref_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .sck_i, .sel_n_i, .sdi_i,
    .sdo_o, .tx_event_o, .rx_event_o, .error_event_o, .audio_mono_o, .audio_format_o);
  sab_link_model u_link (.sck_o(sck_i), .sel_n_o(sel_n_i), .sdi_o(sdi_i), .sdo_i(sdo_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit done;
    done = 1'b0;
    rs = 2'h3;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int k = 0; k < 64 && !done; k++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o)
      begin
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        done = 1'b1;
      end
    end
    // a response that never comes is a failure, not a silent skip
    if (!done) n_mismatch++;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit done;
    done = 1'b0;
    v = 32'h0;
    rs = 2'h3;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int k = 0; k < 64 && !done; k++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o)
      begin
        v = s_axi_rdata_o;
        rs = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) n_mismatch++;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #100us;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        wr(rows[i].a, rows[i].wd, r);
        chk(32'(r), 32'(rows[i].rs));
      end
      rd(rows[i].a, d, r);
      chk(d & rows[i].m, rows[i].ex);
      chk(32'(r), 32'(rows[i].rs));
    end
    wr(4'h4, 32'h0000_0B8B, r);
    chk(32'({audio_mono_o, audio_format_o}), 32'h7);
    wr(4'h4, 32'h0000_0B0B, r);
    chk(32'({audio_mono_o, audio_format_o}), 32'h0);
    wr(4'h4, 32'h0000_0B8B, r);
    // framed, on, 16-bit words, tx event on empty, rx event on not empty
    wr(4'h0, 32'h8000_8405, r);
    wr(4'h4, 32'h0000_0B00, r);
    rd(4'h4, d, r);
    chk(d, 32'h0000_0B8B);
    chk(32'(tx_event_o), 32'h1);
    wr(4'hC, 32'h0000_1234, r);
    rd(4'h8, d, r);
    chk(d & 32'h001F_000B, 32'h0001_0002);
    chk(32'(tx_event_o), 32'h0);
    u_link.xfer(32'h0000_A55A, 16, g1);
    chk(32'(rx_event_o), 32'h1);
    chk(32'(error_event_o), 32'h0);
    u_link.xfer(32'h0000_8001, 16, g2);
    chk(g1, 32'h0000_1234);
    chk(g2, 32'h0000_1234);
    chk(32'(error_event_o), 32'h1);
    u_link.xfer(32'h0000_0000, 16, g3);
    chk(g3, 32'h0);
    rd(4'h8, d, r);
    chk(d & 32'h0000_014B, 32'h0000_0149);
    wr(4'h4, 32'h0000_8B8B, r);
    rd(4'hC, d, r);
    chk(d, 32'hFFFF_A55A);
    chk(32'(rx_event_o), 32'h0);
    wr(4'h8, 32'h0, r);
    rd(4'h8, d, r);
    chk(d & 32'h0000_0040, 32'h0);
    chk(32'(error_event_o), 32'h0);
    wr(4'h4, 32'h0000_9B8B, r);
    // eight clocks of a sixteen-bit word, then select drops: a cut frame
    u_link.xfer(32'h0000_0000, 8, g3);
    chk(32'(error_event_o), 32'h1);
    rd(4'h8, d, r);
    chk(d & 32'h0000_1880, 32'h0000_1000);
    wr(4'h0, 32'h0, r);
    rd(4'h8, d, r);
    chk(d & 32'h0000_0100, 32'h0);
    chk(32'(tx_event_o), 32'h0);
    print_verdict();
  end
endmodule // sab_spi_test
